// File: bench/ddc_sync_and_channel_control_tb.sv
// Self-checking bench for the downconverter sync and channel 0 control bank.
`include "dsc_defs.svh"

module ddc_sync_and_channel_control_tb;
	import dsc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	logic        i_core_clk = 1'b0;     // 25 MHz core clock
	logic        i_reset_n = 1'b0;      // Async reset, active low
	logic [11:0] i_addr = 12'h000;      // Register address
	logic [7:0]  i_wdata = 8'h00;       // Write data
	logic        i_wr = 1'b0;           // Write strobe
	logic        i_rd = 1'b0;           // Read strobe
	logic        i_sysref = 1'b0;       // Timing reference level
	logic        i_sysref_input_en = 1'b1; // Reference input enable
	logic        i_data_valid = 1'b0;   // Sample strobe
	logic [15:0] i_chan_a = 16'h0000;   // Channel A sample
	logic [15:0] i_chan_b = 16'h0000;   // Channel B sample
	logic [7:0]  o_rdata;
	logic        o_ddc_reset, o_nco_align, o_mixer_complex, o_gain_x2, o_c2r_enable;
	logic [1:0]  o_if_mode;
	logic [2:0]  o_decim_log2;
	logic        o_out_valid, o_q_valid;
	logic [15:0] o_i_data, o_q_data;
	int          fails = 0;             // Mismatch count
	int          n_checks = 0;          // Comparison count
	int          cycles = 0;            // Watchdog count

	// Clock at 40 ns period
	always #20 i_core_clk = ~i_core_clk;

	dsc_core i_dsc_core (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sysref(i_sysref), .i_sysref_input_en(i_sysref_input_en),
		.i_data_valid(i_data_valid), .i_chan_a(i_chan_a), .i_chan_b(i_chan_b), .o_ddc_reset(o_ddc_reset),
		.o_nco_align(o_nco_align), .o_mixer_complex(o_mixer_complex), .o_gain_x2(o_gain_x2),
		.o_if_mode(o_if_mode), .o_c2r_enable(o_c2r_enable), .o_decim_log2(o_decim_log2),
		.o_out_valid(o_out_valid), .o_i_data(o_i_data), .o_q_valid(o_q_valid), .o_q_data(o_q_data));

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run; the only exit point
	task automatic final_report();
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog: the whole run needs well under a thousand cycles
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails = fails + 1;
			final_report();
		end
	end

	// Four-state compare, so an unknown never counts as a match
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle write; outputs are looked at once the taking edge has landed
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		#1;
	endtask

	// One-cycle read; data stand in the next cycle only, then return to zero
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
		@(posedge i_core_clk);
		#1 chk(o_rdata, 8'h00);
	endtask

	// One sample in, result judged one cycle later
	task automatic samp(input logic [15:0] a, b, ei, eq, input logic ev, eqv);
		@(posedge i_core_clk);
		i_data_valid <= 1'b1;
		i_chan_a <= a;
		i_chan_b <= b;
		@(posedge i_core_clk);
		i_data_valid <= 1'b0;
		#1 chk(o_out_valid, ev);
		if (ev) begin
			chk(o_i_data, ei);
			chk(o_q_valid, eqv);
			chk(o_q_data, eq);
		end
	endtask

	// Reference rising edge; the realign pulse is due two cycles after the edge cycle
	task automatic pulse_sysref(input logic exp);
		@(posedge i_core_clk);
		i_sysref <= 1'b1;
		@(posedge i_core_clk);
		#1 chk(o_nco_align, 1'b0);
		@(posedge i_core_clk);
		i_sysref <= 1'b0;
		#1 chk(o_nco_align, exp);
		@(posedge i_core_clk);
		#1 chk(o_nco_align, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, reserved bits and an unmapped address
	task automatic t_regs();
		chk(o_decim_log2, 3'h2);
		rd(`DSC_ADDR_SYNC, 8'h00);
		rd(`DSC_ADDR_DDC0, 8'h00);
		wr(`DSC_ADDR_SYNC, 8'hec);
		rd(`DSC_ADDR_SYNC, 8'hc0);
		wr(`DSC_ADDR_SYNC, 8'h00);
		wr(`DSC_ADDR_DDC0, 8'hff);
		rd(`DSC_ADDR_DDC0, 8'hfb);
		wr(12'h301, 8'h55);
		rd(12'h301, 8'h00);
		rd(`DSC_ADDR_SYNC, 8'h00);
	endtask

	// Every field value, decimation code and complex-to-real setting
	task automatic t_fields();
		logic [7:0] v;
		logic [2:0] e;
		for (int k = 0; k < 8; k++) begin
			v = {k[0], k[1], k[1:0], k[2], 1'b0, k[1:0]};
			e = (k[1:0] == 2'h3) ? 3'h1 : 3'(k[1:0]) + 3'h2;
			wr(`DSC_ADDR_DDC0, v);
			chk(o_mixer_complex, k[0]);
			chk(o_gain_x2, k[1]);
			chk(o_if_mode, k[1:0]);
			chk(o_c2r_enable, k[2]);
			chk(o_decim_log2, e - 3'(k[2]));
		end
	endtask

	// Mixer sources, gain, saturation, quarter-rate conversion and soft reset
	task automatic t_data();
		wr(`DSC_ADDR_DDC0, 8'h50);
		samp(16'h0100, 16'h0333, 16'h0200, 16'h0200, 1'b1, 1'b1);
		wr(`DSC_ADDR_DDC0, 8'h10);
		samp(16'h0100, 16'h0333, 16'h0100, 16'h0100, 1'b1, 1'b1);
		wr(`DSC_ADDR_DDC0, 8'h90);
		samp(16'h1234, 16'h0567, 16'h1234, 16'h0567, 1'b1, 1'b1);
		wr(`DSC_ADDR_DDC0, 8'hd0);
		samp(16'h7000, 16'h9000, 16'h7fff, 16'h8000, 1'b1, 1'b1);
		wr(`DSC_ADDR_DDC0, 8'h88);
		wr(`DSC_ADDR_SYNC, 8'h10);
		chk(o_ddc_reset, 1'b1);
		samp(16'h0010, 16'h0020, 16'h0000, 16'h0000, 1'b0, 1'b0);
		wr(`DSC_ADDR_SYNC, 8'h00);
		chk(o_ddc_reset, 1'b0);
		samp(16'h0010, 16'h0020, 16'h0010, 16'h0000, 1'b1, 1'b0);
		samp(16'h0010, 16'h0020, 16'hffe0, 16'h0000, 1'b1, 1'b0);
		samp(16'h0010, 16'h0020, 16'hfff0, 16'h0000, 1'b1, 1'b0);
		samp(16'h0010, 16'h0020, 16'h0020, 16'h0000, 1'b1, 1'b0);
		wr(`DSC_ADDR_DDC0, 8'hb0);
		// Ramp restarted at the soft reset release and has counted four samples since
		samp(16'h0000, 16'h0000, 16'h0004, 16'hfffb, 1'b1, 1'b1);
		chk(o_if_mode, 2'h3);
		samp(16'h0000, 16'h0000, 16'h0005, 16'hfffa, 1'b1, 1'b1);
	endtask

	// Continuous and one-shot alignment, with every refusal case
	task automatic t_sync();
		pulse_sysref(1'b0);
		wr(`DSC_ADDR_SYNC, 8'h01);
		repeat (2) @(posedge i_core_clk);
		pulse_sysref(1'b1);
		pulse_sysref(1'b1);
		rd(`DSC_ADDR_SYNC, 8'h01);
		@(posedge i_core_clk);
		i_sysref_input_en <= 1'b0;
		pulse_sysref(1'b0);
		@(posedge i_core_clk);
		i_sysref_input_en <= 1'b1;
		wr(`DSC_ADDR_SYNC, 8'h11);
		repeat (2) @(posedge i_core_clk);
		pulse_sysref(1'b0);
		wr(`DSC_ADDR_SYNC, 8'h00);
		repeat (2) @(posedge i_core_clk);
		pulse_sysref(1'b0);
		wr(`DSC_ADDR_SYNC, 8'h03);
		repeat (2) @(posedge i_core_clk);
		pulse_sysref(1'b1);
		rd(`DSC_ADDR_SYNC, 8'h02);
		pulse_sysref(1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (6) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		@(posedge i_core_clk);
		#1;
		t_regs();
		t_fields();
		t_data();
		t_sync();
		final_report();
	end
endmodule

// File: design/dsc_core.sv
// Downconverter sync control and channel 0 control registers with their output stage.
//
// Design decision made here: the address-and-strobe port.
`include "dsc_defs.svh"

// Functional notes
// R1: Soft reset bit holds all downconverters reset
// R2: One-shot uses next edge; else every edge
// R3: SYSREF period must be oscillator period multiple
// R4: One-shot clears sync enable after edge
// R5: No sync while enable bit or input off
// R6: Mixer select: real shares channel, complex separate
// R7: Gain select doubles output for 6 dB
// R8: IF mode: variable, zero, quarter-rate, test
// R9: Complex-to-real outputs real I stream only
// R10: Without complex-to-real, I and Q valid
// R11: Decimation code; halved under complex-to-real
module dsc_core
	import dsc_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_reset_n,
	input  wire logic [11:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	input  wire logic        i_sysref,
	input  wire logic        i_sysref_input_en,
	input  wire logic        i_data_valid,
	input  wire logic [15:0] i_chan_a,
	input  wire logic [15:0] i_chan_b,
	output logic             o_ddc_reset,
	output logic             o_nco_align,
	output logic             o_mixer_complex,
	output logic             o_gain_x2,
	output logic      [1:0]  o_if_mode,
	output logic             o_c2r_enable,
	output logic      [2:0]  o_decim_log2,
	output logic             o_out_valid,
	output logic      [15:0] o_i_data,
	output logic             o_q_valid,
	output logic      [15:0] o_q_data
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Saturating negate; the most negative code has no positive twin
	function automatic logic [15:0] dsc_neg(input logic [15:0] x);
		if (x == `DSC_SAMPLE_MIN) begin
			return `DSC_SAMPLE_MAX;
		end
		return 16'(~x + 16'h0001);
	endfunction

	// Optional saturating doubling
	function automatic logic [15:0] dsc_gain(input logic [15:0] x, input logic en);
		if (!en) begin
			return x;
		end else if (x[15] != x[14]) begin
			// Clip instead of wrapping so overrange stays monotonic
			return x[15] ? `DSC_SAMPLE_MIN : `DSC_SAMPLE_MAX;
		end
		return {x[14:0], 1'b0};
	endfunction

	// Decimation as a power of two from the rate code
	function automatic logic [2:0] dsc_decim(input logic [1:0] code, input logic c2r);
		logic [2:0] f;
		f = 3'h0;
		case (code)
			2'h3:    f = 3'h1;
			2'h0:    f = 3'h2;
			2'h1:    f = 3'h3;
			default: f = 3'h4;
		endcase
		// Real output needs one half-band stage less of rate reduction
		return c2r ? 3'(f - 3'h1) : f;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	dsc_core_s    s;       // Registered state
	dsc_core_s    next_s;  // Next state
	dsc_if_mode_e if_mode; // Decoded IF mode
	logic [15:0]  src_i;   // Selected I source
	logic [15:0]  src_q;   // Selected Q source
	logic [15:0]  gain_i;  // I after gain
	logic [15:0]  gain_q;  // Q after gain
	logic [15:0]  mix_r;   // Quarter-rate mixed real sample
	logic         wr_sync; // Write to the sync register
	logic         wr_ddc0; // Write to the channel 0 register

	dsc_sync_if sif ();

	////////////////////////////////////////////////////////////////////////////
	// Sync unit

	assign sif.sync_en    = s.sync_reg[`DSC_SYNC_EN_BIT];
	assign sif.one_shot   = s.sync_reg[`DSC_ONE_SHOT_BIT];
	assign sif.soft_reset = s.sync_reg[`DSC_NCO_RST_BIT];

	// The SYSREF source is trusted to run at a multiple of the oscillator period
	dsc_sync_unit u_sync ( // [R3]
		.i_core_clk       (i_core_clk),
		.i_reset_n        (i_reset_n),
		.i_sysref         (i_sysref),
		.i_sysref_input_en(i_sysref_input_en),
		.sif              (sif)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sample path selection

	assign wr_sync = i_wr && (i_addr == `DSC_ADDR_SYNC);
	assign wr_ddc0 = i_wr && (i_addr == `DSC_ADDR_DDC0);
	assign if_mode = dsc_if_mode_e'(s.ddc0_reg[`DSC_IF_MSB:`DSC_IF_LSB]);

	// Source, gain and quarter-rate mix
	always_comb begin
		src_i = i_chan_a;
		// Real mixer feeds both arms from one channel
		src_q = s.ddc0_reg[`DSC_MIXER_BIT] ? i_chan_b : i_chan_a; // [R6]
		// Test mode replaces the samples with a ramp
		if (if_mode == DSC_IF_TEST) begin // [R8]
			src_i = s.ramp;
			src_q = ~s.ramp;
		end
		gain_i = dsc_gain(src_i, s.ddc0_reg[`DSC_GAIN_BIT]); // [R7]
		gain_q = dsc_gain(src_q, s.ddc0_reg[`DSC_GAIN_BIT]); // [R7]
		// cos/sin at fs/4 take only 0 and +-1, so no multiplier
		case (s.phase)
			2'h0:    mix_r = gain_i;
			2'h1:    mix_r = dsc_neg(gain_q);
			2'h2:    mix_r = dsc_neg(gain_i);
			default: mix_r = gain_q;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s       = s;
		next_s.rdata = 8'h00;
		next_s.align = sif.align; // [R2]
		// Register writes; a software write beats a one-shot clear
		if (wr_sync) begin
			next_s.sync_reg = i_wdata & `DSC_SYNC_WMASK;
		end else if (sif.clear_en) begin
			next_s.sync_reg[`DSC_SYNC_EN_BIT] = 1'b0; // [R4]
		end
		if (wr_ddc0) begin
			next_s.ddc0_reg = i_wdata & `DSC_DDC0_WMASK;
		end
		// Reads answer next cycle; unmapped addresses read zero
		if (i_rd) begin
			if (i_addr == `DSC_ADDR_SYNC) begin
				next_s.rdata = s.sync_reg;
			end else if (i_addr == `DSC_ADDR_DDC0) begin
				next_s.rdata = s.ddc0_reg;
			end
		end
		next_s.decim = dsc_decim(next_s.ddc0_reg[`DSC_DECIM_MSB:`DSC_DECIM_LSB],
			next_s.ddc0_reg[`DSC_C2R_BIT]); // [R11]
		// Output stage
		if (s.sync_reg[`DSC_NCO_RST_BIT]) begin
			// Held in reset: everything restarts aligned on release
			next_s.out_valid = 1'b0; // [R1]
			next_s.q_valid   = 1'b0; // [R1]
			next_s.phase     = 2'h0; // [R1]
			next_s.ramp      = 16'h0000;
			next_s.i_data    = 16'h0000;
			next_s.q_data    = 16'h0000;
		end else if (i_data_valid) begin
			next_s.out_valid = 1'b1;
			next_s.ramp      = 16'(s.ramp + 16'h0001);
			if (s.ddc0_reg[`DSC_C2R_BIT]) begin
				// Real output only on I
				next_s.i_data  = mix_r; // [R9]
				next_s.q_data  = 16'h0000; // [R9]
				next_s.q_valid = 1'b0; // [R9]
				next_s.phase   = 2'(s.phase + 2'h1);
			end else begin
				next_s.i_data  = gain_i; // [R10]
				next_s.q_data  = gain_q; // [R10]
				next_s.q_valid = 1'b1; // [R10]
			end
		end else begin
			next_s.out_valid = 1'b0;
			next_s.q_valid   = 1'b0;
		end
		// A realign restarts the local phase
		if (sif.align) begin
			next_s.phase = 2'h0; // [R2]
			next_s.ramp  = 16'h0000;
		end
	end

	// State register
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s          <= '0;
			s.sync_reg <= `DSC_SYNC_RESET;
			s.ddc0_reg <= `DSC_DDC0_RESET;
			s.decim    <= 3'h2;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_rdata         = s.rdata;
	assign o_ddc_reset     = s.sync_reg[`DSC_NCO_RST_BIT]; // [R1]
	assign o_nco_align     = s.align;
	assign o_mixer_complex = s.ddc0_reg[`DSC_MIXER_BIT]; // [R6]
	assign o_gain_x2       = s.ddc0_reg[`DSC_GAIN_BIT]; // [R7]
	assign o_if_mode       = s.ddc0_reg[`DSC_IF_MSB:`DSC_IF_LSB]; // [R8]
	assign o_c2r_enable    = s.ddc0_reg[`DSC_C2R_BIT]; // [R9]
	assign o_decim_log2    = s.decim; // [R11]
	assign o_out_valid     = s.out_valid;
	assign o_i_data        = s.i_data;
	assign o_q_valid       = s.q_valid;
	assign o_q_data        = s.q_data;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	AST_RESET_HOLDS: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R1]
		o_ddc_reset |=> (!o_out_valid && !o_q_valid && o_i_data == 16'h0000))
		else $error("Output active while held in soft reset");

	AST_RESET_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R1]
		(wr_sync && i_wdata[`DSC_NCO_RST_BIT]) |=> o_ddc_reset ##1 !o_out_valid)
		else $error("Soft reset write not applied");

	AST_ENABLE_DROPS: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R4]
		(sif.clear_en && !wr_sync) |=> !s.sync_reg[`DSC_SYNC_EN_BIT])
		else $error("One-shot did not clear sync enable");

	AST_NO_SYNC_OFF: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R5]
		(!s.sync_reg[`DSC_SYNC_EN_BIT] || !i_sysref_input_en) ##1 !s.sync_reg[`DSC_SYNC_EN_BIT]
		|=> !o_nco_align)
		else $error("Realign while sync disabled");

	AST_REAL_MIXER: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R6]
		(i_data_valid && !s.sync_reg[`DSC_NCO_RST_BIT] && !s.ddc0_reg[`DSC_MIXER_BIT]
		&& !s.ddc0_reg[`DSC_GAIN_BIT] && !s.ddc0_reg[`DSC_C2R_BIT] && if_mode != DSC_IF_TEST)
		|=> (o_q_data == $past(i_chan_a) && o_i_data == $past(i_chan_a)))
		else $error("Real mixer Q not from I channel");

	AST_GAIN_DOUBLES: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R7]
		(i_data_valid && !s.sync_reg[`DSC_NCO_RST_BIT] && s.ddc0_reg[`DSC_GAIN_BIT]
		&& !s.ddc0_reg[`DSC_C2R_BIT] && if_mode != DSC_IF_TEST && i_chan_a[15] == i_chan_a[14])
		|=> o_i_data == {$past(i_chan_a[14:0]), 1'b0})
		else $error("Gain select did not double");

	AST_C2R_NO_Q: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R9]
		$past(o_c2r_enable) |-> !o_q_valid)
		else $error("Q valid under complex-to-real");

	AST_IQ_VALID: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R10]
		(o_out_valid && !$past(o_c2r_enable)) |-> o_q_valid)
		else $error("Q not valid in complex output");

	AST_DECIM_HALF: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R11]
		(s.ddc0_reg[`DSC_DECIM_MSB:`DSC_DECIM_LSB] == 2'h2) |-> o_decim_log2 == (o_c2r_enable ? 3'h3 : 3'h4))
		else $error("Decimation factor wrong");

	// Phase and ramp must sit at zero so every channel restarts in step
	AST_RESET_PHASE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R1]
		o_ddc_reset |=> (s.phase == 2'h0 && s.ramp == 16'h0000))
		else $error("Phase not cleared in soft reset");

	// Edges need a low sample between them, so realign pulses never touch
	AST_ALIGN_ONE_CYCLE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R2]
		o_nco_align |=> !o_nco_align)
		else $error("Realign pulse longer than one cycle");

	// Complex mixer takes its two arms from separate channels
	AST_MIXER_COMPLEX: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R6]
		(i_data_valid && !s.sync_reg[`DSC_NCO_RST_BIT] && s.ddc0_reg[`DSC_MIXER_BIT]
		&& !s.ddc0_reg[`DSC_GAIN_BIT] && !s.ddc0_reg[`DSC_C2R_BIT] && if_mode != DSC_IF_TEST)
		|=> (o_i_data == $past(i_chan_a) && o_q_data == $past(i_chan_b)))
		else $error("Complex mixer arms not from separate channels");

	// Test pattern: Q is the bitwise inverse of the I ramp
	AST_TEST_Q_INV: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R8]
		(i_data_valid && !s.sync_reg[`DSC_NCO_RST_BIT] && if_mode == DSC_IF_TEST
		&& !s.ddc0_reg[`DSC_GAIN_BIT] && !s.ddc0_reg[`DSC_C2R_BIT])
		|=> o_q_data == ~o_i_data)
		else $error("Test pattern Q not inverse of I");

	// Real output leaves the Q word at zero
	AST_C2R_Q_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R9]
		(o_out_valid && $past(o_c2r_enable)) |-> o_q_data == 16'h0000)
		else $error("Q data present under complex-to-real");

	// Every accepted sample produces one output word
	AST_OUT_FOLLOWS: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R10]
		(i_data_valid && !o_ddc_reset) |=> o_out_valid)
		else $error("Accepted sample gave no output");

endmodule

// File: design/dsc_defs.svh
// Register offsets, field positions, masks and reset values of the downconverter sync and control bank.
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// Register addresses
`define DSC_ADDR_SYNC     12'h300
`define DSC_ADDR_DDC0     12'h310

// Sync control fields
`define DSC_SYNC_EN_BIT   0
`define DSC_ONE_SHOT_BIT  1
`define DSC_NCO_RST_BIT   4
`define DSC_SYNC_WMASK    8'hd3
`define DSC_SYNC_RESET    8'h00

// Downconverter 0 control fields
`define DSC_MIXER_BIT     7
`define DSC_GAIN_BIT      6
`define DSC_IF_MSB        5
`define DSC_IF_LSB        4
`define DSC_C2R_BIT       3
`define DSC_DECIM_MSB     1
`define DSC_DECIM_LSB     0
`define DSC_DDC0_WMASK    8'hfb
`define DSC_DDC0_RESET    8'h00

// Sample limits
`define DSC_SAMPLE_MAX    16'h7fff
`define DSC_SAMPLE_MIN    16'h8000

`endif

// File: design/dsc_pkg.sv
// Types shared by the downconverter sync and control bank.
package dsc_pkg;

	// IF mode field encodings, in field order
	typedef enum logic [1:0] {
		DSC_IF_VAR,
		DSC_IF_ZERO,
		DSC_IF_FS4,
		DSC_IF_TEST
	} dsc_if_mode_e;

	// Sync unit states
	typedef enum logic [1:0] {
		DSC_SY_IDLE,
		DSC_SY_ARMED,
		DSC_SY_DONE
	} dsc_sync_state_e;

	// Sync unit state
	typedef struct packed {
		dsc_sync_state_e state;
		logic            sysref_q;
		logic            align;
		logic            clear_en;
	} dsc_sync_s;

	// Core state
	typedef struct packed {
		logic [7:0]  sync_reg;
		logic [7:0]  ddc0_reg;
		logic [7:0]  rdata;
		logic        align;
		logic [2:0]  decim;
		logic        out_valid;
		logic        q_valid;
		logic [1:0]  phase;
		logic [15:0] ramp;
		logic [15:0] i_data;
		logic [15:0] q_data;
	} dsc_core_s;

endpackage

// File: design/dsc_sync_if.sv
// Carrier between the register core and the sync unit.
interface dsc_sync_if;
	logic sync_en;     // Sync enable bit
	logic one_shot;    // One-shot select bit
	logic soft_reset;  // Oscillator soft reset bit
	logic align;       // Realign pulse
	logic clear_en;    // Request to drop the sync enable bit

	modport ctrl (output sync_en, output one_shot, output soft_reset, input align, input clear_en);
	modport unit (input sync_en, input one_shot, input soft_reset, output align, output clear_en);
endinterface

// File: design/dsc_sync_unit.sv
// SYSREF edge qualifier that issues oscillator realign pulses.
`include "dsc_defs.svh"

module dsc_sync_unit
	import dsc_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_reset_n,
	input  wire logic i_sysref,
	input  wire logic i_sysref_input_en,
	dsc_sync_if.unit  sif
);

	dsc_sync_s s;       // Registered state
	dsc_sync_s next_s;  // Next state
	logic      edge_ok; // Qualified rising SYSREF edge

	// Rising edge, only while the SYSREF input itself is enabled
	assign edge_ok = i_sysref & ~s.sysref_q & i_sysref_input_en; // [R5]

	// Next state
	always_comb begin
		next_s          = s;
		next_s.sysref_q = i_sysref;
		next_s.align    = 1'b0;
		next_s.clear_en = 1'b0;
		case (s.state)
			DSC_SY_IDLE: begin
				// Arm only when enabled and not held in reset
				if (sif.sync_en && !sif.soft_reset) begin // [R5]
					next_s.state = DSC_SY_ARMED;
				end
			end
			DSC_SY_ARMED: begin
				if (!sif.sync_en || sif.soft_reset) begin // [R5]
					next_s.state = DSC_SY_IDLE;
				end else if (edge_ok) begin
					next_s.align = 1'b1; // [R2]
					// One-shot: drop the enable and ignore later edges
					if (sif.one_shot) begin
						next_s.clear_en = 1'b1; // [R4]
						next_s.state    = DSC_SY_DONE; // [R2]
					end
				end
			end
			DSC_SY_DONE: begin
				// Wait for the enable bit to fall so one edge cannot fire twice
				if (!sif.sync_en) begin
					next_s.state = DSC_SY_IDLE;
				end
			end
			default: begin
				next_s.state = DSC_SY_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sif.align    = s.align;
	assign sif.clear_en = s.clear_en;

	AST_ONESHOT_CLEARS: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R4]
		s.align |-> (s.clear_en == $past(sif.one_shot)))
		else $error("One-shot align did not request enable clear");

	AST_CONTINUOUS_ALIGN: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R2]
		(s.state == DSC_SY_ARMED && edge_ok && sif.sync_en && !sif.soft_reset && !sif.one_shot)
		|=> (s.align && !s.clear_en && s.state == DSC_SY_ARMED))
		else $error("Continuous edge did not realign");

endmodule
